// ---- dv/cmb_can_node.sv ----
// Behavioural model of the bus and protocol engine facing the store
`timescale 1ns/1ps
module cmb_can_node (
    input  wire logic       clock,
    output logic            bitTick,
    output logic            sofStart,
    output logic            txDone,
    output logic            txAbandon,
    output logic      [3:0] txByteAddr,
    output logic            frameAck,
    output logic            rxWrite,
    output logic      [3:0] rxByteAddr,
    output logic      [7:0] rxByteData,
    output logic            rxEnd,
    output logic            rxAccepted,
    output logic            rxOwnFrame
);
    // ********************************
    // Bit clock and engine strobes
    // ********************************
    logic [1:0] div = 2'h0;
    initial begin
        {sofStart, txDone, txAbandon, frameAck, rxWrite, rxEnd} = '0;
        {txByteAddr, rxByteAddr, rxByteData, rxAccepted, rxOwnFrame} = '0;
    end
    // Bit clock free running at a quarter of the system clock
    always @(posedge clock) div <= div + 2'h1;
    assign bitTick = (div == 2'h3);

    task automatic start();
        sofStart <= 1'b1;
        txByteAddr <= 4'hD;
        @(posedge clock);
        sofStart <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // Acknowledge seen on the bus, then success or loss of the frame
    task automatic finish(input logic ok);
        frameAck <= 1'b1;
        @(posedge clock);
        frameAck <= 1'b0;
        txDone <= ok;
        txAbandon <= !ok;
        @(posedge clock);
        txDone <= 1'b0;
        txAbandon <= 1'b0;
        @(posedge clock);
    endtask

    task automatic recv(input logic acc, input logic own, input logic [7:0] base);
        for (int i = 0; i < 13; i++) begin
            rxWrite <= 1'b1;
            rxByteAddr <= i[3:0];
            rxByteData <= base + i[7:0];
            @(posedge clock);
        end
        // Released data lines show the inverse, never a stale copy
        rxWrite <= 1'b0;
        rxByteData <= ~rxByteData;
        rxEnd <= 1'b1;
        frameAck <= acc;
        rxAccepted <= acc;
        rxOwnFrame <= own;
        @(posedge clock);
        rxEnd <= 1'b0;
        frameAck <= 1'b0;
        rxAccepted <= !acc;
        rxOwnFrame <= !own;
        @(posedge clock);
    endtask
endmodule

// ---- dv/cmb_store_checker.sv ----
// Port assertions for the CAN message buffer store
`timescale 1ns/1ps
module cmb_store_checker (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       wbCyc,
    input wire logic       wbStb,
    input wire logic       wbAck,
    input wire logic       sofStart,
    input wire logic       txDone,
    input wire logic       txAbandon,
    input wire logic       txActive,
    input wire logic [1:0] txIndex,
    input wire logic       rxEnd,
    input wire logic       rxAccepted,
    input wire logic       rxOwnFrame,
    input wire logic       busAckEnable,
    input wire logic       txReleaseEvent,
    input wire logic       rxEvent,
    input wire logic       overrunEvent
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ********************************
    // Assertions
    // ********************************
    bus_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("bus answer late or long");
    tx_start_a: assert property ($rose(txActive) |-> $past(sofStart))
        else $error("send began without start of frame");
    tx_hold_a: assert property (txActive && !txDone && !txAbandon |=> txActive && $stable(txIndex))
        else $error("active send dropped");
    tx_done_a: assert property (txActive && txDone |=> !txActive && txReleaseEvent)
        else $error("sent buffer not released");
    tx_retry_a: assert property (txActive && txAbandon |=> $fell(txActive))
        else $error("lost frame still active");
    idx_range_a: assert property (txActive |-> txIndex <= 2'h2)
        else $error("buffer index out of range");
    rx_push_a: assert property (rxEvent |-> $past(rxEnd && rxAccepted))
        else $error("receive event without frame");
    rx_drop_a: assert property (rxEnd && !rxAccepted |=> !rxEvent && !overrunEvent)
        else $error("invalid frame queued");
    ovr_cause_a: assert property (overrunEvent |-> $past(rxEnd && rxAccepted) && !rxEvent)
        else $error("overrun without discarded frame");
    rx_take_a: assert property (rxEnd && rxAccepted && !rxOwnFrame |=> rxEvent || overrunEvent)
        else $error("accepted frame ignored");
    ack_ctl_a: assert property (!txActive |-> busAckEnable)
        else $error("bus acknowledge blocked while idle");
    cover property (txActive && txDone);
    cover property (txActive && txAbandon);
    cover property (overrunEvent);
    cover property (rxEvent);
endmodule

bind cmb_message_store cmb_store_checker chk (.*);

// ---- dv/tb_cmb_message_store.sv ----
// Self-checking testbench for the CAN message buffer store
`timescale 1ns/1ps
module tb_cmb_message_store
    import cmb_pkg::*;
;
    // ********************************
    // Signals and models
    // ********************************
    localparam logic [7:0] WIN_LOCAL_PRIORITY = 8'h74;
    localparam logic [7:0] WIN_STH  = 8'h78;
    localparam logic [7:0] WIN_STL  = 8'h7C;
    localparam logic [7:0] WIN_RX   = 8'h80;
    logic        clock = 1'b0;
    logic        reset_n, wbCyc, wbStb, wbWe, wbAck, bitTick, sofStart, txDone;
    logic        txAbandon, frameAck, rxWrite, rxEnd, rxAccepted, rxOwnFrame, txActive;
    logic        busAckEnable, txReleaseEvent, rxEvent, overrunEvent;
    logic [3:0]  wbSel, txByteAddr, rxByteAddr;
    logic [7:0]  wbAdr, txByte, rxByteData;
    logic [1:0]  txIndex;
    logic [31:0] wbDatW, wbDatR, rdv;
    logic [15:0] stamp;
    logic [7:0]  local_priority [3] = '{8'h05, 8'h02, 8'h02};
    int          n_errors = 0, samples_checked = 0, nRx = 0, nOvr = 0, nRel = 0;

    always #12.5 clock = ~clock;
    cmb_message_store dut (.*);
    cmb_can_node bus (.*);
    always @(posedge clock) begin
        nRx <= nRx + int'(rxEvent === 1'b1);
        nOvr <= nOvr + int'(overrunEvent === 1'b1);
        nRel <= nRel + int'(txReleaseEvent === 1'b1);
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic cycle held until ack is sampled; no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, w, a, d};
        @(posedge clock);
        while (wbAck !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        if (wbAck !== 1'b1) begin
            n_errors++;
            $display("[ERR] wb ack expected 1 seen %b", wbAck);
        end
        rdv = wbDatR;
        {wbCyc, wbStb} <= 2'b00;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, rdv, e);
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clock);
        n_errors++;
        stop_test();
    end

    // ********************************
    // Test sequence
    // ********************************
    initial begin
        {reset_n, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
        wbSel = 4'hF;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd(CMB_ADR_CTRL, 32'h1, "ctrl");
        rd(CMB_ADR_TXFLAG, 32'h7, "txflag");
        rd(8'hFC, 32'h0, "unmapped");
        repeat (40) @(posedge clock);
        rd(CMB_ADR_TIMER, 32'h0, "timer init");
        wb(1'b1, CMB_ADR_CTRL, 32'h2);
        repeat (40) @(posedge clock);
        wb(1'b1, CMB_ADR_TIMER, 32'hFFFF);
        wb(1'b0, CMB_ADR_TIMER, 32'h0);
        chk("timer", 32'(rdv >= 32'h8 && rdv <= 32'hE), 32'h1);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, CMB_ADR_TXSEL, 32'h1 << i);
            wb(1'b1, WIN_LOCAL_PRIORITY, {24'h0, local_priority[i]});
            rd(WIN_LOCAL_PRIORITY, {24'h0, local_priority[i]}, "local_priority");
        end
        wb(1'b1, CMB_ADR_TXFLAG, 32'h7);
        rd(CMB_ADR_TXFLAG, 32'h0, "pending");
        wb(1'b1, CMB_ADR_TXSEL, 32'h1);
        rd(WIN_LOCAL_PRIORITY, 32'h0, "hidden");
        bus.start();
        chk("pick", 32'(txIndex), 32'h1);
        chk("self ack", 32'(busAckEnable), 32'h0);
        chk("txByte", 32'(txByte), 32'h2);
        bus.finish(1'b0);
        bus.start();
        chk("repick", 32'(txIndex), 32'h1);
        wb(1'b1, CMB_ADR_ABTREQ, 32'h2);
        bus.finish(1'b1);
        rd(CMB_ADR_TXFLAG, 32'h2, "sent");
        rd(CMB_ADR_ABTACK, 32'h0, "not aborted");
        wb(1'b1, CMB_ADR_ABTREQ, 32'h1);
        repeat (3) @(posedge clock);
        rd(CMB_ADR_ABTACK, 32'h1, "aborted");
        rd(CMB_ADR_TXFLAG, 32'h3, "released");
        wb(1'b1, CMB_ADR_TXSEL, 32'h2);
        wb(1'b0, WIN_STH, 32'h0);
        stamp[15:8] = rdv[7:0];
        wb(1'b0, WIN_STL, 32'h0);
        stamp[7:0] = rdv[7:0];
        wb(1'b1, WIN_STL, {24'h0, ~stamp[7:0]});
        rd(WIN_STL, {24'h0, stamp[7:0]}, "stamp ro");
        wb(1'b0, CMB_ADR_TIMER, 32'h0);
        chk("stamp", 32'(stamp != 16'h0 && stamp <= rdv[15:0]), 32'h1);
        bus.start();
        chk("last", 32'(txIndex), 32'h2);
        bus.finish(1'b1);
        rd(CMB_ADR_TXFLAG, 32'h7, "all free");
        chk("releases", nRel, 32'h3);
        bus.recv(1'b0, 1'b0, 8'h10);
        bus.recv(1'b1, 1'b1, 8'h20);
        rd(CMB_ADR_RXFLAG, 32'h0, "dropped");
        for (int i = 0; i < 6; i++) begin
            bus.recv(1'b1, 1'b0, 8'h30 + 8'(i * 16));
        end
        rd(CMB_ADR_RXFLAG, 32'h3, "overrun");
        chk("rx events", nRx, 32'h5);
        chk("ovr events", nOvr, 32'h1);
        rd(WIN_RX, 32'h30, "oldest");
        wb(1'b1, CMB_ADR_RXFLAG, 32'h3);
        rd(WIN_RX, 32'h40, "next");
        wb(1'b1, CMB_ADR_CTRL, 32'h6);
        bus.recv(1'b1, 1'b1, 8'hB0);
        @(posedge clock);
        chk("loopback", nRx, 32'h6);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, CMB_ADR_RXFLAG, 32'h1);
        end
        rd(WIN_RX, 32'hB0, "own entry");
        wb(1'b0, WIN_RX + 8'h34, 32'h0);
        stamp[15:8] = rdv[7:0];
        wb(1'b0, WIN_RX + 8'h38, 32'h0);
        stamp[7:0] = rdv[7:0];
        chk("rx stamp", 32'(stamp != 16'h0), 32'h1);
        wb(1'b1, CMB_ADR_RXFLAG, 32'h1);
        rd(CMB_ADR_RXFLAG, 32'h0, "empty");
        stop_test();
    end
endmodule

// ---- hw/cmb_message_store.sv ----
// CAN message buffer store: transmit buffers, receive FIFO, stamping timer
`timescale 1ns/1ps
module cmb_message_store
    import cmb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic      [31:0] wbDatR,
    output logic             wbAck,
    input  wire logic        bitTick,
    input  wire logic        sofStart,
    input  wire logic        txDone,
    input  wire logic        txAbandon,
    input  wire logic [3:0]  txByteAddr,
    output logic      [7:0]  txByte,
    output logic             txActive,
    output logic      [1:0]  txIndex,
    input  wire logic        frameAck,
    input  wire logic        rxWrite,
    input  wire logic [3:0]  rxByteAddr,
    input  wire logic [7:0]  rxByteData,
    input  wire logic        rxEnd,
    input  wire logic        rxAccepted,
    input  wire logic        rxOwnFrame,
    output logic             busAckEnable,
    output logic             txReleaseEvent,
    output logic             rxEvent,
    output logic             overrunEvent
);

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        cmb_txstate_t               txState;
        logic [1:0]                 txIdx;
        logic [2:0]                 txEmpty;
        logic [2:0]                 txSelect;
        logic [2:0]                 abortReq;
        logic [2:0]                 abortAck;
        logic [2:0][15:0][7:0]      txBuf;
        logic [14:0][7:0]           bgBuf;
        logic [4:0][14:0][7:0]      fifo;
        logic [2:0]                 wrPtr;
        logic [2:0]                 rdPtr;
        logic [2:0]                 count;
        logic                       overrun;
        logic [2:0]                 ctrl;
        logic [15:0]                timer;
        logic                       ack;
        logic [31:0]                rdData;
        logic [7:0]                 engByte;
        logic                       relEvt;
        logic                       rxEvt;
        logic                       ovrEvt;
    } cmb_state_t;

    cmb_state_t state_q;
    cmb_state_t state_d;
    logic [1:0] rstSync_q;
    logic       rstInt_n;

    // ********************************
    // Reset release
    // ********************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstInt_n = rstSync_q[1];

    // ********************************
    // Per-buffer arbitration inputs
    // ********************************
    logic [2:0]      eligible;
    logic [2:0][7:0] localPrio;
    logic [2:0]      abortGrant;
    genvar gi;
    generate
        for (gi = 0; gi < CMB_NTX; gi++) begin : g_tx
            assign eligible[gi]  = !state_q.txEmpty[gi];
            assign localPrio[gi] = state_q.txBuf[gi][CMB_TX_LOCAL_PRIORITY];
            // Buffer on the bus keeps its request until it is returned
            assign abortGrant[gi] = state_q.abortReq[gi] && !state_q.txEmpty[gi]
                && !(state_q.txState == CMB_TX_SEND && state_q.txIdx == 2'(gi));
        end
    endgenerate

    function automatic logic [2:0] ptrNext(input logic [2:0] p);
        ptrNext = (p == CMB_FIFO_LAST) ? 3'h0 : p + 3'h1;
    endfunction

    function automatic logic [1:0] lowestIdx(input logic [2:0] v);
        lowestIdx = v[0] ? 2'h0 : (v[1] ? 2'h1 : 2'h2);
    endfunction

    // ********************************
    // Next state
    // ********************************
    logic        winFound;
    logic [1:0]  winIdx;
    logic [7:0]  winPrio;
    logic [1:0]  selIdx;
    logic        selValid;
    logic        busReq;
    logic        busWr;
    logic [3:0]  winByte;
    logic [31:0] rdWord;
    logic [7:0]  wrByte;
    logic        popReq;
    logic        pushReq;

    always_comb begin
        state_d = state_q;

        // ********************************
        // Priority arbitration
        // ********************************
        winFound = 1'b0;
        winIdx = 2'h0;
        winPrio = 8'hFF;
        for (int i = 0; i < CMB_NTX; i++) begin
            // Strict less-than keeps the lower index on a tie
            if (eligible[i] && (!winFound || localPrio[i] < winPrio)) begin
                winFound = 1'b1;
                winIdx = 2'(i);
                winPrio = localPrio[i];
            end
        end

        // ********************************
        // Window and bus decode
        // ********************************
        selValid = state_q.txSelect != 3'h0;
        selIdx = lowestIdx(state_q.txSelect);
        busReq = wbCyc && wbStb && !state_q.ack;
        busWr = busReq && wbWe && wbSel[0];
        winByte = wbAdr[5:2];
        wrByte = wbDatW[7:0];
        popReq = 1'b0;
        pushReq = 1'b0;
        state_d.relEvt = 1'b0;
        state_d.rxEvt = 1'b0;
        state_d.ovrEvt = 1'b0;

        // ********************************
        // Stamping timer
        // ********************************
        if (state_q.ctrl[CMB_CTRL_INIT]) begin
            state_d.timer = 16'h0000;
        end else if (bitTick) begin
            state_d.timer = state_q.timer + 16'h0001;
        end

        // ********************************
        // Transmit scheduling
        // ********************************
        case (state_q.txState)
            CMB_TX_IDLE: begin
                if (sofStart && winFound) begin
                    state_d.txState = CMB_TX_SEND;
                    state_d.txIdx = winIdx;
                end
            end
            CMB_TX_SEND: begin
                if (txDone) begin
                    state_d.txEmpty[state_q.txIdx] = 1'b1;
                    state_d.abortAck[state_q.txIdx] = 1'b0;
                    state_d.abortReq[state_q.txIdx] = 1'b0;
                    state_d.relEvt = 1'b1;
                    state_d.txState = CMB_TX_IDLE;
                end else if (txAbandon) begin
                    // Lost arbitration or error: stays pending, rearbitrated
                    state_d.txState = CMB_TX_IDLE;
                end
            end
            default: begin
                state_d.txState = CMB_TX_IDLE;
            end
        endcase

        // ********************************
        // Abort grant, never for the buffer on the bus
        // ********************************
        for (int i = 0; i < CMB_NTX; i++) begin
            if (abortGrant[i]) begin
                state_d.abortAck[i] = 1'b1;
                state_d.txEmpty[i] = 1'b1;
                state_d.abortReq[i] = 1'b0;
                state_d.relEvt = 1'b1;
            end
        end

        // ********************************
        // Stamp on acknowledge
        // ********************************
        if (frameAck && state_q.ctrl[CMB_CTRL_TIME]) begin
            if (state_q.txState == CMB_TX_SEND) begin
                state_d.txBuf[state_q.txIdx][CMB_TX_STAMPH] = state_q.timer[15:8];
                state_d.txBuf[state_q.txIdx][CMB_TX_STAMPL] = state_q.timer[7:0];
            end else begin
                state_d.bgBuf[CMB_RX_STAMPH] = state_q.timer[15:8];
                state_d.bgBuf[CMB_RX_STAMPL] = state_q.timer[7:0];
            end
        end

        // ********************************
        // Background buffer fill
        // ********************************
        if (rxWrite && rxByteAddr < CMB_MSG_BYTES) begin
            state_d.bgBuf[rxByteAddr] = rxByteData;
        end

        // ********************************
        // End of frame: queue, drop or overrun
        // ********************************
        if (rxEnd && rxAccepted && (!rxOwnFrame || state_q.ctrl[CMB_CTRL_LOOP])) begin
            if (state_q.count == CMB_FIFO_FULL) begin
                state_d.overrun = 1'b1;
                state_d.ovrEvt = 1'b1;
            end else begin
                pushReq = 1'b1;
                state_d.fifo[state_q.wrPtr] = state_q.bgBuf;
                if (frameAck && state_q.ctrl[CMB_CTRL_TIME]
                    && state_q.txState != CMB_TX_SEND) begin
                    state_d.fifo[state_q.wrPtr][CMB_RX_STAMPH] = state_q.timer[15:8];
                    state_d.fifo[state_q.wrPtr][CMB_RX_STAMPL] = state_q.timer[7:0];
                end
                state_d.wrPtr = ptrNext(state_q.wrPtr);
                state_d.rxEvt = 1'b1;
            end
        end

        // ********************************
        // Register writes
        // ********************************
        if (busWr) begin
            case (wbAdr[7:6])
                2'h0: begin
                    case (wbAdr)
                        CMB_ADR_CTRL: begin
                            state_d.ctrl = wrByte[2:0];
                        end
                        CMB_ADR_TXFLAG: begin
                            for (int i = 0; i < CMB_NTX; i++) begin
                                // Writing one schedules an empty buffer
                                if (wrByte[i] && state_q.txEmpty[i]) begin
                                    state_d.txEmpty[i] = 1'b0;
                                    state_d.abortAck[i] = 1'b0;
                                end
                            end
                        end
                        CMB_ADR_TXSEL: begin
                            state_d.txSelect = wrByte[2:0] & state_q.txEmpty;
                        end
                        CMB_ADR_ABTREQ: begin
                            state_d.abortReq = state_d.abortReq
                                             | (wrByte[2:0] & ~state_d.txEmpty);
                        end
                        CMB_ADR_RXFLAG: begin
                            if (wrByte[CMB_RX_FULL] && state_q.count != 3'h0) begin
                                popReq = 1'b1;
                            end
                            // Overrun set in this cycle wins over the clear
                            if (wrByte[CMB_RX_OVR] && !state_d.ovrEvt) begin
                                state_d.overrun = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                CMB_WIN_TX: begin
                    // Stamp bytes take no write
                    if (selValid && state_q.txEmpty[selIdx]
                        && winByte <= CMB_TX_LOCAL_PRIORITY) begin
                        state_d.txBuf[selIdx][winByte] = wrByte;
                    end
                end
                default: begin
                end
            endcase
        end

        if (popReq) begin
            state_d.rdPtr = ptrNext(state_q.rdPtr);
        end
        state_d.count = state_q.count + (pushReq ? 3'h1 : 3'h0) - (popReq ? 3'h1 : 3'h0);

        // ********************************
        // Register reads
        // ********************************
        rdWord = 32'h0000_0000;
        case (wbAdr[7:6])
            2'h0: begin
                case (wbAdr)
                    CMB_ADR_CTRL:   rdWord[2:0] = state_q.ctrl;
                    CMB_ADR_TXFLAG: rdWord[2:0] = state_q.txEmpty;
                    CMB_ADR_TXSEL:  rdWord[2:0] = state_q.txSelect;
                    CMB_ADR_ABTREQ: rdWord[2:0] = state_q.abortReq;
                    CMB_ADR_ABTACK: rdWord[2:0] = state_q.abortAck;
                    CMB_ADR_RXFLAG: begin
                        rdWord[CMB_RX_FULL] = state_q.count != 3'h0;
                        rdWord[CMB_RX_OVR] = state_q.overrun;
                    end
                    CMB_ADR_TIMER:  rdWord[15:0] = state_q.timer;
                    default: begin
                    end
                endcase
            end
            CMB_WIN_TX: begin
                if (selValid && state_q.txEmpty[selIdx]) begin
                    rdWord[7:0] = state_q.txBuf[selIdx][winByte];
                end
            end
            CMB_WIN_RX: begin
                // Only the foreground entry is visible
                if (state_q.count != 3'h0 && winByte < CMB_RX_BYTES) begin
                    rdWord[7:0] = state_q.fifo[state_q.rdPtr][winByte];
                end
            end
            default: begin
            end
        endcase

        // ********************************
        // Bus answer one cycle after the request
        // ********************************
        state_d.ack = busReq;
        if (busReq) begin
            state_d.rdData = rdWord;
        end

        // ********************************
        // Engine byte port, registered; only valid while sending
        // ********************************
        state_d.engByte = state_q.txBuf[state_q.txIdx][txByteAddr];
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge clock or negedge rstInt_n) begin
        if (!rstInt_n) begin
            state_q <= '0;
            state_q.txState <= CMB_TX_IDLE;
            state_q.txEmpty <= CMB_TXEMPTY_RST;
            state_q.ctrl <= CMB_CTRL_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign wbAck = state_q.ack;
    assign wbDatR = state_q.rdData;
    assign txByte = state_q.engByte;
    assign txActive = state_q.txState == CMB_TX_SEND;
    assign txIndex = state_q.txIdx;
    // Own frames are not acknowledged unless looped back
    assign busAckEnable = state_q.ctrl[CMB_CTRL_LOOP] || state_q.txState != CMB_TX_SEND;
    assign txReleaseEvent = state_q.relEvt;
    assign rxEvent = state_q.rxEvt;
    assign overrunEvent = state_q.ovrEvt;

endmodule

// ---- hw/cmb_pkg.sv ----
// Constants, register map and types for the CAN message buffer store
// Summary of operation
// - Stamp active buffer on bus acknowledge
// - Timer runs on bit clock, silent wrap
// - Timer held at zero in init mode
// - Stamp bytes read-only, gated by empty/select
// - Three transmit buffers: message, priority, stamp
// - Successful send sets empty, signals release
// - Lowest priority value wins every arbitration
// - Active message never aborted; request only
// - Abort: acknowledge, empty and event set in the same cycle
// - Acknowledge flag tells aborted from sent
// - Five-entry receive FIFO, foreground visible
// - Full flag shows foreground holds message
// - Background fills; valid frame pushed, event
// - Invalid background frame simply overwritten
// - Own frames not queued outside loopback
// - Loopback treats own frames as received
// - Full FIFO discards frame, flags overrun
// - Only pending buffers compete, at start-of-frame
// - Equal priority: lower index wins
package cmb_pkg;

    // ********************************
    // Register map (byte addresses)
    // ********************************
    localparam logic [7:0] CMB_ADR_CTRL    = 8'h00;
    localparam logic [7:0] CMB_ADR_TXFLAG  = 8'h04;
    localparam logic [7:0] CMB_ADR_TXSEL   = 8'h08;
    localparam logic [7:0] CMB_ADR_ABTREQ  = 8'h0C;
    localparam logic [7:0] CMB_ADR_ABTACK  = 8'h10;
    localparam logic [7:0] CMB_ADR_RXFLAG  = 8'h14;
    localparam logic [7:0] CMB_ADR_TIMER   = 8'h18;
    localparam logic [1:0] CMB_WIN_TX      = 2'h1;
    localparam logic [1:0] CMB_WIN_RX      = 2'h2;

    // ********************************
    // Field positions
    // ********************************
    localparam int CMB_CTRL_INIT = 0;
    localparam int CMB_CTRL_TIME = 1;
    localparam int CMB_CTRL_LOOP = 2;
    localparam int CMB_RX_FULL   = 0;
    localparam int CMB_RX_OVR    = 1;

    // ********************************
    // Buffer layout
    // ********************************
    localparam int         CMB_NTX        = 3;
    localparam int         CMB_NFIFO      = 5;
    localparam logic [2:0] CMB_FIFO_LAST  = 3'h4;
    localparam logic [2:0] CMB_FIFO_FULL  = 3'h5;
    localparam logic [3:0] CMB_MSG_BYTES  = 4'hD;
    localparam logic [3:0] CMB_TX_LOCAL_PRIORITY    = 4'hD;
    localparam logic [3:0] CMB_TX_STAMPH  = 4'hE;
    localparam logic [3:0] CMB_TX_STAMPL  = 4'hF;
    localparam logic [3:0] CMB_RX_STAMPH  = 4'hD;
    localparam logic [3:0] CMB_RX_STAMPL  = 4'hE;
    localparam logic [3:0] CMB_RX_BYTES   = 4'hF;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [2:0] CMB_TXEMPTY_RST = 3'h7;
    localparam logic [2:0] CMB_CTRL_RST    = 3'h1;

    typedef enum logic [1:0] {
        CMB_TX_IDLE = 2'b01,
        CMB_TX_SEND = 2'b10
    } cmb_txstate_t;

endpackage
